//--- design/twc_bus_if.sv
`timescale 1ns/10ps
interface twc_bus_if;
  logic dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe;
  logic par_scl_o, par_scl_oe, par_sda_o, par_sda_oe;
  logic scl, sda;

  // Open-drain lines with pull-up: any enabled low driver wins
  assign scl = !((dev_scl_oe && !dev_scl_o) || (par_scl_oe && !par_scl_o));
  assign sda = !((dev_sda_oe && !dev_sda_o) || (par_sda_oe && !par_sda_o));

  modport dev (output dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe, input scl, sda);
  modport par (output par_scl_o, par_scl_oe, par_sda_o, par_sda_oe, input scl, sda);
endinterface

//--- design/twc_defs.svh
`ifndef TWC_DEFS_SVH
`define TWC_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define TWC_OFF_CTRL   8'h00
`define TWC_OFF_DATA   8'h04
`define TWC_OFF_STAT   8'h08
`define TWC_OFF_ADDR   8'h0C

// ----------------------------------------------------------------
// Control register bit positions
// ----------------------------------------------------------------
`define TWC_CB_RATE2   7
`define TWC_CB_PE      6
`define TWC_CB_STA     5
`define TWC_CB_STO     4
`define TWC_CB_SI      3
`define TWC_CB_AA      2
`define TWC_CB_RATE1   1
`define TWC_CB_RATE0   0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TWC_OWN_RST    8'h00
`define TWC_STAT_RST   8'hF8

// ----------------------------------------------------------------
// Half-bit periods: peripheral clock divisor / 2, timer 1 overflows
// ----------------------------------------------------------------
`define TWC_HDIV0      8'h40
`define TWC_HDIV1      8'h38
`define TWC_HDIV2      8'h30
`define TWC_HDIV3      8'h28
`define TWC_HDIV4      8'hF0
`define TWC_HDIV5      8'h1E
`define TWC_HDIV6      8'h0F
`define TWC_HDIV_T1    8'h30
`define TWC_RATE_T1    3'h7

// ----------------------------------------------------------------
// Status codes
// ----------------------------------------------------------------
`define TWC_ST_BUSERR  8'h00
`define TWC_ST_START   8'h08
`define TWC_ST_RSTART  8'h10
`define TWC_ST_MTA_ACK 8'h18
`define TWC_ST_MTA_NAK 8'h20
`define TWC_ST_MTD_ACK 8'h28
`define TWC_ST_MTD_NAK 8'h30
`define TWC_ST_LOST    8'h38
`define TWC_ST_MRA_ACK 8'h40
`define TWC_ST_MRA_NAK 8'h48
`define TWC_ST_MRD_ACK 8'h50
`define TWC_ST_MRD_NAK 8'h58
`define TWC_ST_SRA     8'h60
`define TWC_ST_SRA_LST 8'h68
`define TWC_ST_SRG     8'h70
`define TWC_ST_SRG_LST 8'h78
`define TWC_ST_SRD_ACK 8'h80
`define TWC_ST_SRD_NAK 8'h88
`define TWC_ST_SGD_ACK 8'h90
`define TWC_ST_SGD_NAK 8'h98
`define TWC_ST_SR_STOP 8'hA0
`define TWC_ST_STA     8'hA8
`define TWC_ST_STA_LST 8'hB0
`define TWC_ST_STD_ACK 8'hB8
`define TWC_ST_STD_NAK 8'hC0
`define TWC_ST_STD_LST 8'hC8

`endif

//--- design/twc_dev.sv
`timescale 1ns/10ps
`include "twc_defs.svh"

// Functional notes
// RULE_01 - Four byte registers: control, data, status, address
// RULE_02 - Reset leaves controller disabled
// RULE_03 - Status low three bits read zero
// RULE_04 - Twenty-six status codes reported
// RULE_05 - Idle code F8 when nothing pending
// RULE_06 - Status valid while event flag set
// RULE_07 - Data register written only while flag set
// RULE_08 - Data register stable while flag set
// RULE_09 - Shift in bus data while shifting out
// RULE_10 - Slave answers own seven-bit address
// RULE_11 - Address bit zero enables general call
// RULE_12 - Control holds enable, rate, ack, start, stop, flag
// RULE_13 - Master/slave transmit/receive with multimaster arbitration
// RULE_14 - Acknowledge is data low, not-ack high
// RULE_15 - Direction bit high read, low write
// RULE_16 - Transfer suspended until flag cleared
// RULE_17 - Three-bit rate select, seven fixed plus programmable
// RULE_18 - Fixed rates divide clock; programmable uses timer overflow
// RULE_19 - Low-speed rate limited to 100 kbit/s
// RULE_20 - Sent START sets flag with code 08
// RULE_21 - Cleared ack enable: nack next byte, ignore address
// RULE_22 - Interrupt request follows the event flag
module twc_dev import twc_pkg::*; (
  input  wire logic        CLK_SYS,  // System clock
  input  wire logic        RESETN,   // Asynchronous reset, active low
  input  wire logic        PSEL,     // APB select
  input  wire logic        PENABLE,  // APB enable
  input  wire logic        PWRITE,   // APB write
  input  wire logic [7:0]  PADDR,    // APB byte address
  input  wire logic [31:0] PWDATA,   // APB write data
  output logic      [31:0] PRDATA,   // APB read data
  output logic             PREADY,   // APB ready
  output logic             PSLVERR,  // APB error on unmapped address
  input  wire logic        T1_OVF,   // Timer 1 overflow pulse
  output logic             IRQ,      // Serial interrupt request
  twc_bus_if.dev           TWI_BUS   // Two-wire bus
);

  localparam logic [7:0] ST_IDLE = `TWC_STAT_RST;
  localparam twc_dev_s DEV_RST = '{state: T_IDLE, stat: ST_IDLE[7:3], own: `TWC_OWN_RST,
                                   scl_p: 1'b1, sda_p: 1'b1, default: '0};

  twc_dev_s   s_q, s_d;
  logic       start_det, stop_det, rise, fall, tick_en, run, half, ackd, match, gcm;
  logic [7:0] hdiv, code, wb;

  function automatic twc_dev_s raise(input twc_dev_s v, input logic [7:0] c, input logic hold);
    twc_dev_s r;
    r          = v;
    r.si       = 1'b1;
    r.stat     = c[7:3];
    r.state    = T_HOLD;
    r.hold_scl = hold;
    r.scl_oe   = hold;
    r.sda_oe   = 1'b0;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d       = s_q;
    code      = ST_IDLE;
    wb        = PWDATA[7:0];
    ackd      = !TWI_BUS.sda; // RULE_14
    start_det = s_q.scl_p && TWI_BUS.scl && s_q.sda_p && !TWI_BUS.sda;
    stop_det  = s_q.scl_p && TWI_BUS.scl && !s_q.sda_p && TWI_BUS.sda;
    rise      = TWI_BUS.scl && !s_q.scl_p;
    fall      = !TWI_BUS.scl && s_q.scl_p;
    gcm       = (s_q.shift[7:1] == 7'h00);
    match     = s_q.aa && ((s_q.shift[7:1] == s_q.own[7:1]) || (s_q.own[0] && gcm)); // RULE_10 RULE_11 RULE_21
    s_d.scl_p   = TWI_BUS.scl;
    s_d.sda_p   = TWI_BUS.sda;
    s_d.pready  = 1'b0;
    s_d.pslverr = 1'b0;
    if (start_det) begin
      s_d.busy = 1'b1;
    end else if (stop_det) begin
      s_d.busy = 1'b0;
    end

    // Half-bit timebase; high phases wait for SCL so slow slaves can stretch
    case (s_q.rate) // RULE_17 RULE_18 RULE_19
      3'h0:    hdiv = `TWC_HDIV0;
      3'h1:    hdiv = `TWC_HDIV1;
      3'h2:    hdiv = `TWC_HDIV2;
      3'h3:    hdiv = `TWC_HDIV3;
      3'h4:    hdiv = `TWC_HDIV4;
      3'h5:    hdiv = `TWC_HDIV5;
      3'h6:    hdiv = `TWC_HDIV6;
      default: hdiv = `TWC_HDIV_T1;
    endcase
    tick_en = (s_q.rate == `TWC_RATE_T1) ? T1_OVF : 1'b1; // RULE_18
    run  = (s_q.state inside {T_STA_A, T_STA_B, T_LOW, T_STO_A, T_STO_C}) ||
           ((s_q.state inside {T_HIGH, T_STO_B, T_RSTA}) && TWI_BUS.scl);
    half = run && tick_en && (s_q.cnt == hdiv - 8'h01);
    if (!run) begin
      s_d.cnt = '0;
    end else if (tick_en) begin
      s_d.cnt = half ? '0 : s_q.cnt + 8'h01;
    end

    // ----------------------------------------------------------------
    // Register access
    // ----------------------------------------------------------------
    if (PSEL && !PENABLE) begin
      s_d.pready = 1'b1;
      if (PADDR == `TWC_OFF_CTRL) begin // RULE_01 RULE_12
        s_d.rdata = {s_q.rate[2], s_q.pe, s_q.sta, s_q.sto, s_q.si, s_q.aa, s_q.rate[1:0]};
      end else if (PADDR == `TWC_OFF_DATA) begin
        s_d.rdata = s_q.shift;
      end else if (PADDR == `TWC_OFF_STAT) begin
        s_d.rdata = {s_q.stat, 3'h0}; // RULE_03
      end else if (PADDR == `TWC_OFF_ADDR) begin
        s_d.rdata = s_q.own;
      end else begin
        s_d.rdata   = 8'h00;
        s_d.pslverr = 1'b1;
      end
    end
    if (PSEL && PENABLE && s_q.pready && PWRITE && !s_q.pslverr) begin
      if (PADDR == `TWC_OFF_CTRL) begin // RULE_12
        s_d.pe   = wb[`TWC_CB_PE];
        s_d.sta  = wb[`TWC_CB_STA];
        s_d.sto  = wb[`TWC_CB_STO];
        s_d.aa   = wb[`TWC_CB_AA];
        s_d.rate = {wb[`TWC_CB_RATE2], wb[`TWC_CB_RATE1], wb[`TWC_CB_RATE0]};
        if (!wb[`TWC_CB_SI]) begin
          s_d.si   = 1'b0;
          s_d.stat = ST_IDLE[7:3]; // RULE_05
        end
      end else if (PADDR == `TWC_OFF_DATA && s_q.si) begin
        s_d.shift = wb; // RULE_07
      end else if (PADDR == `TWC_OFF_ADDR) begin
        s_d.own = wb;
      end
    end

    // ----------------------------------------------------------------
    // Bus engine; a flag set here overrides a clear in the same cycle
    // ----------------------------------------------------------------
    case (s_q.state)
      T_IDLE: begin
        s_d.scl_oe = 1'b0;
        s_d.sda_oe = 1'b0;
        s_d.mst    = 1'b0;
        if (start_det) begin
          s_d.state   = T_SLV;
          s_d.addr_ph = 1'b1;
          // The START's own SCL fall is no bit: count from minus one
          s_d.bitn    = 4'hF;
          s_d.tx      = 1'b0;
          s_d.lost    = 1'b0;
        end else if (s_q.sta && !s_q.busy) begin
          s_d.state = T_STA_A;
          s_d.mst   = 1'b1;
          s_d.rs    = 1'b0;
        end
      end
      T_RSTA: begin
        s_d.scl_oe = 1'b0;
        s_d.sda_oe = 1'b0;
        if (half) begin
          s_d.state = T_STA_A;
          s_d.rs    = 1'b1;
        end
      end
      T_STA_A: begin
        s_d.sda_oe = 1'b1;
        if (half) s_d.state = T_STA_B;
      end
      T_STA_B: begin
        s_d.scl_oe = 1'b1;
        if (half) begin
          s_d.addr_ph = 1'b1;
          s_d.tx      = 1'b1;
          s_d = raise(s_d, s_q.rs ? `TWC_ST_RSTART : `TWC_ST_START, 1'b1); // RULE_20
        end
      end
      T_LOW: begin
        s_d.scl_oe = 1'b1;
        s_d.sda_oe = (s_q.bitn == 4'h8) ? (!s_q.tx && s_q.aa) : (s_q.tx && !s_q.shift[7]);
        if (half) begin
          s_d.state  = T_HIGH;
          s_d.scl_oe = 1'b0;
        end
      end
      T_HIGH: begin
        if (start_det || stop_det) begin
          s_d.mst = 1'b0;
          s_d = raise(s_d, `TWC_ST_BUSERR, 1'b0);
        end else if (half && s_q.bitn != 4'h8) begin
          s_d.shift = {s_q.shift[6:0], TWI_BUS.sda}; // RULE_09
          if (s_q.tx && s_q.shift[7] && !TWI_BUS.sda) begin // RULE_13
            s_d.mst    = 1'b0;
            s_d.lost   = 1'b1;
            s_d.sda_oe = 1'b0;
            if (s_q.addr_ph) s_d.state = T_SLV;
            else s_d = raise(s_d, `TWC_ST_LOST, 1'b0);
          end else begin
            s_d.bitn   = s_q.bitn + 4'h1;
            s_d.state  = T_LOW;
            s_d.scl_oe = 1'b1;
          end
        end else if (half) begin
          if (s_q.addr_ph && s_q.dir) code = ackd ? `TWC_ST_MRA_ACK : `TWC_ST_MRA_NAK;
          else if (s_q.addr_ph) code = ackd ? `TWC_ST_MTA_ACK : `TWC_ST_MTA_NAK;
          else if (s_q.tx) code = ackd ? `TWC_ST_MTD_ACK : `TWC_ST_MTD_NAK;
          else code = s_q.sda_oe ? `TWC_ST_MRD_ACK : `TWC_ST_MRD_NAK;
          s_d.tx      = s_q.addr_ph ? !s_q.dir : s_q.tx;
          s_d.addr_ph = 1'b0;
          s_d = raise(s_d, code, 1'b1);
        end
      end
      T_HOLD: begin
        s_d.scl_oe = s_q.hold_scl; // RULE_16
        if (!s_q.si && s_q.mst) begin
          if (s_q.sta) begin
            s_d.state  = T_RSTA;
            s_d.scl_oe = 1'b0;
          end else if (s_q.sto) begin
            s_d.state = T_STO_A;
          end else begin
            s_d.state = T_LOW;
            s_d.bitn  = 4'h0;
            if (s_q.addr_ph) s_d.dir = s_q.shift[0]; // RULE_15
          end
        end else if (!s_q.si && s_q.addressed) begin
          s_d.state  = T_SLV;
          s_d.bitn   = 4'h0;
          s_d.scl_oe = 1'b0;
          s_d.sda_oe = s_q.tx && !s_q.shift[7];
        end else if (!s_q.si) begin
          s_d.state  = T_IDLE;
          s_d.scl_oe = 1'b0;
        end
      end
      T_STO_A: begin
        s_d.scl_oe = 1'b1;
        s_d.sda_oe = 1'b1;
        if (half) s_d.state = T_STO_B;
      end
      T_STO_B: begin
        s_d.scl_oe = 1'b0;
        if (half) s_d.state = T_STO_C;
      end
      T_STO_C: begin
        s_d.sda_oe = 1'b0;
        if (half) begin
          s_d.state = T_IDLE;
          s_d.sto   = 1'b0;
        end
      end
      T_SLV: begin
        s_d.scl_oe = 1'b0;
        if ((start_det || stop_det) && s_q.addressed && !s_q.tx) begin
          s_d.addressed = 1'b0;
          s_d = raise(s_d, `TWC_ST_SR_STOP, 1'b0);
        end else if (start_det || stop_det) begin
          s_d.state     = start_det ? T_SLV : T_IDLE;
          s_d.addr_ph   = 1'b1;
          s_d.bitn      = start_det ? 4'hF : 4'h0;
          s_d.tx        = 1'b0;
          s_d.sda_oe    = 1'b0;
          s_d.lost      = 1'b0;
          s_d.addressed = 1'b0;
        end else begin
          if (rise && s_q.bitn != 4'h8) s_d.shift = {s_q.shift[6:0], TWI_BUS.sda}; // RULE_09
          if (rise && s_q.bitn == 4'h8) s_d.acked = ackd;
          if (fall && s_q.bitn == 4'h7) begin
            s_d.bitn   = 4'h8;
            s_d.gc     = gcm;
            s_d.sda_oe = s_q.addr_ph ? match : (!s_q.tx && s_q.aa && s_q.addressed); // RULE_21
          end else if (fall && s_q.bitn == 4'h8 && s_q.addr_ph) begin
            if (s_q.sda_oe) begin
              s_d.addressed = 1'b1;
              s_d.addr_ph   = 1'b0;
              s_d.tx        = s_q.shift[0]; // RULE_15
              if (s_q.shift[0]) code = s_q.lost ? `TWC_ST_STA_LST : `TWC_ST_STA;
              else if (s_q.gc) code = s_q.lost ? `TWC_ST_SRG_LST : `TWC_ST_SRG;
              else code = s_q.lost ? `TWC_ST_SRA_LST : `TWC_ST_SRA;
              s_d = raise(s_d, code, 1'b1); // RULE_04
            end else if (s_q.lost) begin
              s_d = raise(s_d, `TWC_ST_LOST, 1'b0);
            end else begin
              s_d.state = T_IDLE;
            end
          end else if (fall && s_q.bitn == 4'h8) begin
            if (s_q.tx && !s_q.acked) code = `TWC_ST_STD_NAK;
            else if (s_q.tx) code = s_q.aa ? `TWC_ST_STD_ACK : `TWC_ST_STD_LST;
            else if (s_q.sda_oe) code = s_q.gc ? `TWC_ST_SGD_ACK : `TWC_ST_SRD_ACK;
            else code = s_q.gc ? `TWC_ST_SGD_NAK : `TWC_ST_SRD_NAK;
            s_d.addressed = s_q.tx ? (s_q.acked && s_q.aa) : s_q.sda_oe;
            s_d = raise(s_d, code, 1'b1); // RULE_06 RULE_16
          end else if (fall) begin
            s_d.bitn   = s_q.bitn + 4'h1;
            s_d.sda_oe = s_q.tx && !s_q.shift[7];
          end
        end
      end
      default: s_d.state = T_IDLE;
    endcase

    if (!s_q.pe) begin // RULE_02
      s_d.state     = T_IDLE;
      s_d.si        = 1'b0;
      s_d.stat      = ST_IDLE[7:3];
      s_d.scl_oe    = 1'b0;
      s_d.sda_oe    = 1'b0;
      s_d.mst       = 1'b0;
      s_d.addressed = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      s_q <= DEV_RST; // RULE_02
    end else begin
      s_q <= s_d; // RULE_08
    end
  end

  assign PRDATA             = {24'h000000, s_q.rdata};
  assign PREADY             = s_q.pready;
  assign PSLVERR            = s_q.pslverr;
  assign IRQ                = s_q.si; // RULE_22
  assign TWI_BUS.dev_scl_o  = 1'b0;
  assign TWI_BUS.dev_sda_o  = 1'b0;
  assign TWI_BUS.dev_scl_oe = s_q.scl_oe;
  assign TWI_BUS.dev_sda_oe = s_q.sda_oe;

endmodule

//--- design/twc_par.sv
`timescale 1ns/10ps

module twc_par import twc_pkg::*; #(
  parameter logic [6:0] OWN_ADDR = 7'h2A  // Slave address answered
) (
  input  wire logic       CLK_SYS,    // System clock
  input  wire logic       RESETN,     // Asynchronous reset, active low
  twc_bus_if.par          TWI_BUS,    // Two-wire bus
  input  wire logic [7:0] TX_DATA,    // Byte returned on reads
  input  wire logic       ACK_EN,     // Acknowledge received bytes
  output logic      [7:0] RX_DATA,    // Last byte written by master
  output logic            RX_VALID,   // Pulse: RX_DATA updated
  output logic            ADDRESSED   // Selected by the master
);

  localparam twc_par_s PAR_RST = '{st: P_IDLE, scl_p: 1'b1, sda_p: 1'b1, default: '0};

  twc_par_s s_q, s_d;
  logic     start_det, stop_det, rise, fall;

  // ----------------------------------------------------------------
  // Slave bit engine; never stretches the clock
  // ----------------------------------------------------------------
  always_comb begin
    s_d          = s_q;
    start_det    = s_q.scl_p && TWI_BUS.scl && s_q.sda_p && !TWI_BUS.sda;
    stop_det     = s_q.scl_p && TWI_BUS.scl && !s_q.sda_p && TWI_BUS.sda;
    rise         = TWI_BUS.scl && !s_q.scl_p;
    fall         = !TWI_BUS.scl && s_q.scl_p;
    s_d.scl_p    = TWI_BUS.scl;
    s_d.sda_p    = TWI_BUS.sda;
    s_d.rx_valid = 1'b0;
    if (start_det) begin
      s_d.st        = P_BYTE;
      s_d.addr_ph   = 1'b1;
      // The START's own SCL fall is no bit: count from minus one
      s_d.bitn      = 4'hF;
      s_d.tx        = 1'b0;
      s_d.sda_oe    = 1'b0;
      s_d.addressed = 1'b0;
    end else if (stop_det || s_q.st == P_IDLE) begin
      s_d.st        = P_IDLE;
      s_d.sda_oe    = 1'b0;
      s_d.addressed = 1'b0;
    end else begin
      if (rise && s_q.bitn != 4'h8) s_d.shift = {s_q.shift[6:0], TWI_BUS.sda};
      if (rise && s_q.bitn == 4'h8) s_d.acked = !TWI_BUS.sda; // RULE_14
      if (fall && s_q.bitn == 4'h7) begin
        s_d.bitn = 4'h8;
        if (s_q.addr_ph) begin
          s_d.sda_oe = (s_q.shift[7:1] == OWN_ADDR); // RULE_14
        end else begin
          s_d.sda_oe = !s_q.tx && ACK_EN;
          if (!s_q.tx) begin
            s_d.rx_data  = s_q.shift;
            s_d.rx_valid = 1'b1;
          end
        end
      end else if (fall && s_q.bitn == 4'h8) begin
        s_d.bitn = 4'h0;
        if ((s_q.addr_ph && !s_q.sda_oe) || (!s_q.addr_ph && s_q.tx && !s_q.acked)) begin
          s_d.st     = P_IDLE;
          s_d.sda_oe = 1'b0;
        end else if (s_q.addr_ph ? s_q.shift[0] : s_q.tx) begin // RULE_15
          s_d.addressed = 1'b1;
          s_d.addr_ph   = 1'b0;
          s_d.tx        = 1'b1;
          s_d.shift     = TX_DATA;
          s_d.sda_oe    = !TX_DATA[7];
        end else begin
          s_d.addressed = 1'b1;
          s_d.addr_ph   = 1'b0;
          s_d.sda_oe    = 1'b0;
        end
      end else if (fall) begin
        s_d.bitn   = s_q.bitn + 4'h1;
        s_d.sda_oe = s_q.tx && !s_q.shift[7];
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      s_q <= PAR_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign RX_DATA            = s_q.rx_data;
  assign RX_VALID           = s_q.rx_valid;
  assign ADDRESSED          = s_q.addressed;
  assign TWI_BUS.par_scl_o  = 1'b0;
  assign TWI_BUS.par_sda_o  = 1'b0;
  assign TWI_BUS.par_scl_oe = 1'b0;
  assign TWI_BUS.par_sda_oe = s_q.sda_oe;

endmodule

//--- design/twc_pkg.sv
package twc_pkg;

  typedef enum logic [3:0] {
    T_IDLE  = 4'h0,
    T_STA_A = 4'h1,
    T_STA_B = 4'h3,
    T_HOLD  = 4'h2,
    T_LOW   = 4'h6,
    T_HIGH  = 4'h7,
    T_STO_A = 4'h5,
    T_STO_B = 4'h4,
    T_STO_C = 4'hC,
    T_RSTA  = 4'hD,
    T_SLV   = 4'hF
  } twc_state_e;

  typedef enum logic [0:0] {
    P_IDLE = 1'b0,
    P_BYTE = 1'b1
  } twc_pstate_e;

  typedef struct packed {
    twc_state_e state;
    logic       pe, sta, sto, si, aa;
    logic [2:0] rate;
    logic [7:0] shift, own;
    logic [4:0] stat;
    logic [7:0] cnt;
    logic [3:0] bitn;
    logic       mst, rs, tx, addr_ph, dir, gc, lost, acked, addressed, hold_scl, busy;
    logic       scl_p, sda_p, scl_oe, sda_oe;
    logic [7:0] rdata;
    logic       pready, pslverr;
  } twc_dev_s;

  typedef struct packed {
    twc_pstate_e st;
    logic [7:0]  shift, rx_data;
    logic [3:0]  bitn;
    logic        addr_ph, tx, acked, addressed, rx_valid, scl_p, sda_p, sda_oe;
  } twc_par_s;

endpackage

//--- test/twc_asserts.sv
`timescale 1ns/10ps
module twc_asserts (
  input wire logic CLK_SYS,    // System clock
  input wire logic RESETN,     // Reset, active low
  input wire logic dev_scl_o,  // Controller clock level
  input wire logic dev_scl_oe, // Controller clock pull
  input wire logic dev_sda_o,  // Controller data level
  input wire logic dev_sda_oe, // Controller data pull
  input wire logic par_scl_o,  // Partner clock level
  input wire logic par_scl_oe, // Partner clock pull
  input wire logic par_sda_o,  // Partner data level
  input wire logic par_sda_oe, // Partner data pull
  input wire logic scl,        // Resolved clock line
  input wire logic sda         // Resolved data line
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  // Open drain: a driven high would fight the pull-up
  dev_low_only_a: assert property (!dev_scl_o && !dev_sda_o)
    else $error("controller drives a high level");
  par_low_only_a: assert property (!par_scl_o && !par_sda_o)
    else $error("partner drives a high level");
  par_scl_idle_a: assert property (!par_scl_oe)
    else $error("partner pulls the clock line");
  scl_high_min_a: assert property ($rose(scl) |-> scl[*8])
    else $error("clock high half too short");
  scl_low_min_a: assert property ($fell(scl) |-> !scl[*8])
    else $error("clock low half too short");
  start_owner_a: assert property ($fell(sda) && scl |-> dev_sda_oe ##[1:600] !scl)
    else $error("start not followed by clock low");
  par_sda_lowclk_a: assert property ($changed(par_sda_oe) |-> !scl)
    else $error("partner moved data while clock high");
  stop_free_a: assert property ($rose(sda) && scl && $past(scl) |-> ##1 (scl && sda)[*8])
    else $error("bus not free after stop");
endmodule

//--- test/two_wire_bus_controller_bench.sv
`timescale 1ns/10ps
`include "twc_defs.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module two_wire_bus_controller_bench import twc_pkg::*;;
  logic        clk_sys = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, tx_data = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  logic        ack_en = 1'b1, slv, t1_ovf = 1'b0;
  wire  [31:0] prdata;
  wire  [7:0]  rx_data;
  wire         pready, pslverr, irq, rx_valid, addressed;
  int          fail_count = 0, checked = 0, waited = 0;
  always #12.5 clk_sys = ~clk_sys;
  // Overflow every second clock, so rate 7 cannot pass as a free-running divider
  always @(posedge clk_sys) t1_ovf <= ~t1_ovf;
  twc_bus_if bus_if ();
  twc_dev twc_dev_inst (.CLK_SYS(clk_sys), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .T1_OVF(t1_ovf), .IRQ(irq), .TWI_BUS(bus_if.dev));
  twc_par #(.OWN_ADDR(7'h2A)) twc_par_inst (.CLK_SYS(clk_sys), .RESETN(resetn),
    .TWI_BUS(bus_if.par), .TX_DATA(tx_data), .ACK_EN(ack_en), .RX_DATA(rx_data),
    .RX_VALID(rx_valid), .ADDRESSED(addressed));
  twc_asserts twc_asserts_inst (.CLK_SYS(clk_sys), .RESETN(resetn),
    .dev_scl_o(bus_if.dev_scl_o), .dev_scl_oe(bus_if.dev_scl_oe),
    .dev_sda_o(bus_if.dev_sda_o), .dev_sda_oe(bus_if.dev_sda_oe),
    .par_scl_o(bus_if.par_scl_o), .par_scl_oe(bus_if.par_scl_oe),
    .par_sda_o(bus_if.par_sda_o), .par_sda_oe(bus_if.par_sda_oe),
    .scl(bus_if.scl), .sda(bus_if.sda));
  // ----------------------------------------------------------------
  // Bus helpers
  // ----------------------------------------------------------------
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {24'h000000, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    `CHK(rd, {24'h000000, e})
  endtask
  // Bounded so a silent controller ends in mismatches, not a hang
  // Waits an edge first: the flag seen in the clearing write's own edge is stale
  task wirq;
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (irq !== 1'b1 && n < 3000);
    waited = n;
    `CHK(irq, 1'b1)
  endtask
  task step(input logic [7:0] d, input logic [7:0] c, input logic [7:0] st);
    apb(1'b1, `TWC_OFF_DATA, d);
    apb(1'b1, `TWC_OFF_CTRL, c);
    wirq();
    rchk(`TWC_OFF_STAT, st);
  endtask
  // START takes one half-bit of SDA low, then one of SCL low
  task start_bus(input logic [7:0] c, input int h);
    apb(1'b1, `TWC_OFF_CTRL, c);
    wirq();
    `CHK((waited >= 2 * h - 4) && (waited <= 2 * h + 4), 1'b1)
    rchk(`TWC_OFF_STAT, `TWC_ST_START);
    `CHK(irq, 1'b1)
  endtask
  task stop_bus;
    int n;
    n = 0;
    apb(1'b1, `TWC_OFF_CTRL, 8'hD2);
    do begin
      apb(1'b0, `TWC_OFF_CTRL, 8'h00);
      n++;
    end while (rd[4] !== 1'b0 && n < 200);
    `CHK(rd[4], 1'b0)
    `CHK(irq, 1'b0)
    rchk(`TWC_OFF_STAT, `TWC_STAT_RST);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    rchk(`TWC_OFF_CTRL, 8'h00);
    rchk(`TWC_OFF_STAT, `TWC_STAT_RST);
    rchk(`TWC_OFF_ADDR, `TWC_OWN_RST);
    apb(1'b0, 8'h10, 8'h00);
    `CHK(slv, 1'b1)
    apb(1'b1, `TWC_OFF_STAT, 8'h55);
    rchk(`TWC_OFF_STAT, `TWC_STAT_RST);
    apb(1'b1, `TWC_OFF_ADDR, 8'hA3);
    rchk(`TWC_OFF_ADDR, 8'hA3);
    `CHK(irq, 1'b0)
    $display("TEST reset done");
  endtask
  task t_write;
    start_bus(8'hE6, `TWC_HDIV6);
    step(8'h54, 8'hC6, `TWC_ST_MTA_ACK);
    rchk(`TWC_OFF_DATA, 8'h54);
    `CHK(addressed, 1'b1)
    step(8'hA5, 8'hC6, `TWC_ST_MTD_ACK);
    `CHK(rx_data, 8'hA5)
    repeat (200) @(posedge clk_sys);
    apb(1'b1, `TWC_OFF_CTRL, 8'hCE);
    rchk(`TWC_OFF_CTRL, 8'hCE);
    `CHK(irq, 1'b1)
    rchk(`TWC_OFF_STAT, `TWC_ST_MTD_ACK);
    rchk(`TWC_OFF_DATA, 8'hA5);
    ack_en <= 1'b0;
    step(8'h3C, 8'hC6, `TWC_ST_MTD_NAK);
    stop_bus();
    ack_en <= 1'b1;
    $display("TEST write done");
  endtask
  task t_read;
    tx_data <= 8'hC3;
    start_bus(8'hE6, `TWC_HDIV6);
    step(8'h55, 8'hC6, `TWC_ST_MRA_ACK);
    step(8'hFF, 8'hC6, `TWC_ST_MRD_ACK);
    rchk(`TWC_OFF_DATA, 8'hC3);
    step(8'hFF, 8'hC2, `TWC_ST_MRD_NAK);
    stop_bus();
    $display("TEST read done");
  endtask
  task t_nack;
    apb(1'b1, `TWC_OFF_DATA, 8'h77);
    rchk(`TWC_OFF_DATA, 8'hC3);
    start_bus(8'hE6, `TWC_HDIV6);
    step(8'h66, 8'hC6, `TWC_ST_MTA_NAK);
    `CHK(addressed, 1'b0)
    stop_bus();
    $display("TEST nack done");
  endtask
  task t_timer;
    start_bus(8'hE7, 2 * `TWC_HDIV_T1);
    step(8'h54, 8'hC7, `TWC_ST_MTA_ACK);
    stop_bus();
    $display("TEST timer done");
  endtask
  task tally_and_finish;
    $display("COUNTS checked=%0d mismatches=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reset();
    t_write();
    t_read();
    t_nack();
    t_timer();
    tally_and_finish();
  end
  // Whole run is a few thousand cycles; this margin only catches a hang
  initial begin
    #(25 * 60000);
    fail_count++;
    tally_and_finish();
  end
endmodule
